// file: design/fbrwc_top.sv
// Burst read output control with hold-off signal and APB configuration
module fbrwc_top (
    input  wire logic                         clk_i,
    input  wire logic                         srst_i,
    // APB slave
    input  wire logic                         psel_i,
    input  wire logic                         penable_i,
    input  wire logic                         pwrite_i,
    input  wire logic [fbrwc_pkg::PADDR_W-1:0] paddr_i,
    input  wire logic [31:0]                  pwdata_i,
    output logic      [31:0]                  prdata_o,
    output logic                              pready_o,
    output logic                              pslverr_o,
    // Host-side pins
    input  wire logic                         burst_clk_i,
    input  wire logic                         address_valid_n_i,
    input  wire logic                         chip_enable_n_i,
    input  wire logic                         output_enable_n_i,
    input  wire logic                         write_enable_n_i,
    input  wire logic [fbrwc_pkg::ADDR_W-1:0] addr_i,
    output logic      [fbrwc_pkg::DATA_W-1:0] data_o,
    output logic                              data_oe_n_o,
    output logic                              hold_o,
    output logic                              hold_oe_n_o,
    // Array core side
    input  wire logic                         array_mode_i,
    input  wire logic [fbrwc_pkg::DATA_W-1:0] array_data_i,
    output logic      [fbrwc_pkg::ADDR_W-1:0] array_addr_o
);
    fbrwc_pkg::fbrwc_state_t        state;
    logic [15:0]                    config_word;
    logic [2:0]                     lat_cnt;
    logic [2:0]                     delay_cnt;
    logic [1:0]                     start_off;
    logic                           addr_taken;
    logic                           word_phase;
    logic                           crossed;
    // Hold level out of reset follows the reset polarity bit
    localparam logic CONFIG_HOLD_RESET = fbrwc_pkg::CONFIG_RESET[fbrwc_pkg::POS_WT];

    wire [fbrwc_pkg::SYNC_W-1:0]    pins_s;
    wire                            act_edge;
    wire [fbrwc_pkg::ADDR_W-1:0]    next_addr;

    // Pin synchronisers and active edge detection
    fbrwc_pin_sync u_sync (
        .clk_i      (clk_i),
        .srst_i     (srst_i),
        .pins_i     ({addr_i, write_enable_n_i, output_enable_n_i,
                      chip_enable_n_i, address_valid_n_i, burst_clk_i}),
        .rise_sel_i (config_word[fbrwc_pkg::POS_CC]),
        .pins_o     (pins_s),
        .edge_o     (act_edge)
    );

    // Configuration fields
    wire        read_mode_select;
    wire [2:0]  first_latency_field;
    wire        hold_polarity;
    wire        data_hold_select;
    wire        hold_delay_select;
    wire        burst_wrap_select;
    wire [2:0]  length_field;
    assign read_mode_select    = config_word[fbrwc_pkg::POS_RM];
    assign first_latency_field = config_word[fbrwc_pkg::POS_LC +: 3];
    assign hold_polarity       = config_word[fbrwc_pkg::POS_WT];
    assign data_hold_select    = config_word[fbrwc_pkg::POS_DOC];
    assign hold_delay_select   = config_word[fbrwc_pkg::POS_WC];
    assign burst_wrap_select   = config_word[fbrwc_pkg::POS_BW];
    assign length_field        = config_word[fbrwc_pkg::POS_BL +: 3];

    // Burst address sequencing
    fbrwc_addr_seq u_seq (
        .addr_i     (array_addr_o),
        .length_i   (length_field),
        .wrap_off_i (config_word[fbrwc_pkg::POS_BW]),
        .next_o     (next_addr)
    );

    // Synchronised pin levels
    wire                          adv_low;
    wire                          ce_low;
    wire                          oe_low;
    wire                          we_low;
    wire [fbrwc_pkg::ADDR_W-1:0]  pin_addr;
    assign adv_low  = ~pins_s[fbrwc_pkg::PIN_ADV];
    assign ce_low   = ~pins_s[fbrwc_pkg::PIN_CE];
    assign oe_low   = ~pins_s[fbrwc_pkg::PIN_OE];
    assign we_low   = ~pins_s[fbrwc_pkg::PIN_WE];
    assign pin_addr = pins_s[fbrwc_pkg::PIN_ADDR +: fbrwc_pkg::ADDR_W];

    // Burst qualification
    wire sync_array;
    wire burst_ok;
    assign sync_array = ~read_mode_select & array_mode_i;
    assign burst_ok   = sync_array & ce_low & ~we_low;

    // Latency and data hold decisions
    wire [3:0] lat_next;
    wire       lat_done;
    wire       last_phase;
    assign lat_next   = {1'b0, lat_cnt} + 4'h1;
    assign lat_done   = lat_next >= {1'b0, first_latency_field}; // RULE_18
    assign last_phase = ~data_hold_select | word_phase;          // RULE_07

    // Row crossing detection for linear bursts with misaligned start
    wire       linear_run;
    wire       cross_next;
    assign linear_run = burst_wrap_select | (length_field == fbrwc_pkg::BL_CONT); // RULE_15
    assign cross_next = linear_run & (start_off != fbrwc_pkg::GROUP_START)       // RULE_10
                      & ~crossed                                                 // RULE_11
                      & (next_addr[3:0] == fbrwc_pkg::ROW_START);                // RULE_11

    // Row delay length: latency minus one at the group's last word
    wire [3:0] delay_sum;
    wire [2:0] delay_val;
    assign delay_sum = {1'b0, first_latency_field} + {2'b00, start_off};
    assign delay_val = (delay_sum > fbrwc_pkg::DELAY_BASE)
                     ? 3'(delay_sum - fbrwc_pkg::DELAY_BASE) // RULE_12
                     : 3'h1;

    // Burst sequencer, stepped on the selected burst clock edge
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state        <= fbrwc_pkg::st_idle;
            addr_taken   <= 1'b0;
            lat_cnt      <= 3'h0;
            delay_cnt    <= 3'h0;
            start_off    <= 2'h0;
            word_phase   <= 1'b0;
            crossed      <= 1'b0;
            array_addr_o <= '0;
        end else if (!burst_ok) begin
            state      <= fbrwc_pkg::st_idle;
            addr_taken <= 1'b0;
        end else if (act_edge && adv_low) begin
            // Address capture starts or restarts a burst
            state        <= fbrwc_pkg::st_idle;               // RULE_16
            addr_taken   <= 1'b1;
            array_addr_o <= pin_addr;
            start_off    <= pin_addr[1:0];
            crossed      <= 1'b0;
        end else if (act_edge) begin
            case (state)
                fbrwc_pkg::st_idle: begin
                    if (addr_taken) begin
                        addr_taken <= 1'b0;
                        lat_cnt    <= 3'h1;
                        word_phase <= 1'b0;
                        state      <= (first_latency_field <= 3'h1)
                                    ? fbrwc_pkg::st_data : fbrwc_pkg::st_latency;
                    end
                end
                fbrwc_pkg::st_latency: begin
                    lat_cnt <= lat_next[2:0];
                    if (lat_done) begin
                        state <= fbrwc_pkg::st_data;          // RULE_18
                    end
                end
                fbrwc_pkg::st_data: begin
                    if (!last_phase) begin
                        word_phase <= 1'b1;                   // RULE_07
                    end else begin
                        word_phase   <= 1'b0;
                        array_addr_o <= next_addr;            // RULE_20
                        if (cross_next) begin
                            crossed   <= 1'b1;                // RULE_11
                            delay_cnt <= delay_val;
                            state     <= fbrwc_pkg::st_delay; // RULE_10
                        end
                    end
                end
                fbrwc_pkg::st_delay: begin
                    if (delay_cnt <= 3'h1) begin
                        word_phase <= 1'b0;
                        state      <= fbrwc_pkg::st_data;     // RULE_20
                    end else begin
                        delay_cnt <= delay_cnt - 3'h1;
                    end
                end
                default: begin
                    state <= fbrwc_pkg::st_idle;
                end
            endcase
        end
    end

    // Not-ready condition for the hold pin
    wire data_valid;
    wire early_hold;
    wire not_ready;
    assign data_valid = (state == fbrwc_pkg::st_data);
    assign early_hold = hold_delay_select & data_valid & last_phase & cross_next; // RULE_09
    assign not_ready  = ~sync_array                       // RULE_02 RULE_03
                      | we_low                            // RULE_04
                      | ~data_valid                       // RULE_01
                      | early_hold;                       // RULE_09

    // Host-side outputs, all registered
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            data_o      <= '0;
            data_oe_n_o <= 1'b1;
            hold_o      <= CONFIG_HOLD_RESET;
            hold_oe_n_o <= 1'b1;
        end else begin
            if (data_valid) begin
                data_o <= array_data_i;                    // RULE_07
            end
            data_oe_n_o <= ~(ce_low & oe_low);
            hold_o      <= not_ready ? hold_polarity : ~hold_polarity; // RULE_17
            hold_oe_n_o <= ~ce_low;                        // RULE_05
        end
    end

    // APB decode
    wire        apb_access;
    wire        apb_commit;
    wire        hit_config;
    wire        hit_status;
    wire        hit_any;
    wire [31:0] status_word;
    wire [31:0] next_prdata;
    assign apb_access  = psel_i & penable_i & ~pready_o;
    assign apb_commit  = psel_i & penable_i & pready_o;
    assign hit_config  = (paddr_i == fbrwc_pkg::OFF_CONFIG);
    assign hit_status  = (paddr_i == fbrwc_pkg::OFF_STATUS);
    assign hit_any     = hit_config | hit_status;
    assign status_word = {array_addr_o, 14'h0000,
                          (state == fbrwc_pkg::st_delay),
                          (state != fbrwc_pkg::st_idle)};
    assign next_prdata = pwrite_i   ? 32'h0000_0000 :
                         hit_config ? {16'h0000, config_word} :
                         hit_status ? status_word :
                         32'h0000_0000;

    // APB answer one cycle into the access phase
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= '0;
        end else begin
            pready_o <= apb_access;
            if (apb_access) begin
                pslverr_o <= ~hit_any;
                prdata_o  <= next_prdata;
            end else begin
                pslverr_o <= 1'b0;
                prdata_o  <= '0;
            end
        end
    end

    // Configuration word, reserved bits forced to zero
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            config_word <= fbrwc_pkg::CONFIG_RESET;
        end else if (apb_commit && pwrite_i && hit_config) begin
            config_word <= pwdata_i[15:0] & fbrwc_pkg::CONFIG_WMASK;
        end
    end
endmodule

// file: design/fbrwc_pkg.sv
// Constants, field layout and state type for the burst read hold-off control
// Summary of operation
// RULE_01 - Synchronous array reads: hold deasserted only while valid data is on the bus.
// RULE_02 - Synchronous non-array reads keep hold asserted at the configured polarity.
// RULE_03 - Asynchronous read mode keeps hold asserted.
// RULE_04 - Hold is asserted during every asynchronous read and every write.
// RULE_05 - Hold pin floats while chip enable is high, driven when low.
// RULE_06 - Host ignores hold during asynchronous and non-array reads.
// RULE_07 - Each burst word stays valid for one or two clocks per data hold bit.
// RULE_08 - Host picks one-clock hold only when output delay plus setup fits.
// RULE_09 - Hold delay bit: assert during the delay or one data cycle before.
// RULE_10 - No-wrap and continuous bursts: aligned start gets no row delay.
// RULE_11 - Misaligned start: row delay at most once, only on a real crossing.
// RULE_12 - Start at last word of a group gives delay of latency minus one.
// RULE_13 - Length codes: 1 is 4 words, 2 is 8, 3 is 16, 7 continuous.
// RULE_14 - Wrap on fixed length: increment and wrap inside the aligned group.
// RULE_15 - No wrap or continuous: strictly increasing addresses across boundaries.
// RULE_16 - Clock edge bit picks the edge for burst start, data and hold.
// RULE_17 - Polarity 0 signals not-ready low, polarity 1 signals it high.
// RULE_18 - Latency field counts clocks after address valid rises before first word.
// RULE_19 - Clock edge bit 0 is falling, 1 rising; rising is the default.
// RULE_20 - Row delay holds off, then resumes at the next word with no skip.
package fbrwc_pkg;
    localparam int          ADDR_W       = 16;
    localparam int          DATA_W       = 16;
    localparam int          SYNC_W       = 21;
    localparam int          PADDR_W      = 12;
    // Register byte offsets
    localparam logic [11:0] OFF_CONFIG   = 12'h000;
    localparam logic [11:0] OFF_STATUS   = 12'h004;
    // Configuration word layout
    localparam int          POS_RM       = 15;
    localparam int          POS_LC       = 11;
    localparam int          POS_WT       = 10;
    localparam int          POS_DOC      = 9;
    localparam int          POS_WC       = 8;
    localparam int          POS_BS       = 7;
    localparam int          POS_CC       = 6;
    localparam int          POS_BW       = 3;
    localparam int          POS_BL       = 0;
    localparam logic [15:0] CONFIG_RESET = 16'hbfcf;
    localparam logic [15:0] CONFIG_WMASK = 16'hbfcf;
    // Burst length codes
    localparam logic [2:0]  BL_4         = 3'h1;
    localparam logic [2:0]  BL_8         = 3'h2;
    localparam logic [2:0]  BL_16        = 3'h3;
    localparam logic [2:0]  BL_CONT      = 3'h7;
    localparam logic [15:0] MASK_4       = 16'h0003;
    localparam logic [15:0] MASK_8       = 16'h0007;
    localparam logic [15:0] MASK_16      = 16'h000f;
    // Row and group geometry, row delay offset
    localparam logic [3:0]  ROW_START    = 4'h0;
    localparam logic [1:0]  GROUP_START  = 2'h0;
    localparam logic [3:0]  DELAY_BASE   = 4'h4;
    // Status word layout
    localparam int          POS_ST_BUSY  = 0;
    localparam int          POS_ST_DELAY = 1;
    localparam int          POS_ST_ADDR  = 16;
    // Pin bundle positions
    localparam int          PIN_CLK      = 0;
    localparam int          PIN_ADV      = 1;
    localparam int          PIN_CE       = 2;
    localparam int          PIN_OE       = 3;
    localparam int          PIN_WE       = 4;
    localparam int          PIN_ADDR     = 5;

    typedef enum logic [1:0] {
        st_idle    = 2'b00,
        st_latency = 2'b01,
        st_data    = 2'b11,
        st_delay   = 2'b10
    } fbrwc_state_t;
endpackage

// file: design/fbrwc_pin_sync.sv
// Two-stage pin synchroniser with selectable burst clock edge detection
module fbrwc_pin_sync (
    input  wire logic                       clk_i,
    input  wire logic                       srst_i,
    input  wire logic [fbrwc_pkg::SYNC_W-1:0] pins_i,
    input  wire logic                       rise_sel_i,
    output logic      [fbrwc_pkg::SYNC_W-1:0] pins_o,
    output logic                            edge_o
);
    logic [fbrwc_pkg::SYNC_W-1:0] meta;
    logic                         clk_prev;
    wire                          clk_rise;
    wire                          clk_fall;

    // Two flops per pin, then one more for the clock edge history
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            meta     <= '1;
            pins_o   <= '1;
            clk_prev <= 1'b1;
        end else begin
            meta     <= pins_i;
            pins_o   <= meta;
            clk_prev <= pins_o[fbrwc_pkg::PIN_CLK];
        end
    end

    // Edge chosen by the clock edge bit
    assign clk_rise = pins_o[fbrwc_pkg::PIN_CLK] & ~clk_prev;
    assign clk_fall = ~pins_o[fbrwc_pkg::PIN_CLK] & clk_prev;
    assign edge_o   = rise_sel_i ? clk_rise : clk_fall; // RULE_16 RULE_19
endmodule

// file: design/fbrwc_addr_seq.sv
// Next burst word address for wrap and linear ordering
module fbrwc_addr_seq (
    input  wire logic [fbrwc_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [2:0]                   length_i,
    input  wire logic                         wrap_off_i,
    output logic      [fbrwc_pkg::ADDR_W-1:0] next_o
);
    wire [fbrwc_pkg::ADDR_W-1:0] inc;
    wire [fbrwc_pkg::ADDR_W-1:0] len_mask;
    wire                         wrap_on;

    // Group mask from the length code; unknown codes never wrap
    assign len_mask = (length_i == fbrwc_pkg::BL_4)  ? fbrwc_pkg::MASK_4  : // RULE_13
                      (length_i == fbrwc_pkg::BL_8)  ? fbrwc_pkg::MASK_8  :
                      (length_i == fbrwc_pkg::BL_16) ? fbrwc_pkg::MASK_16 :
                      '0;
    assign inc      = addr_i + 16'h0001;
    assign wrap_on  = ~wrap_off_i & (len_mask != '0);

    // Wrap inside the aligned group, else plain increment
    assign next_o = wrap_on ? ((addr_i & ~len_mask) | (inc & len_mask)) // RULE_14
                            : inc;                                     // RULE_15
endmodule

// file: bench/fbrwc_props.sv
// Concurrent checks on the burst read hold-off control ports
module fbrwc_props (
    input wire logic        clk_i,
    input wire logic        srst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        burst_clk_i,
    input wire logic        chip_enable_n_i,
    input wire logic        output_enable_n_i,
    input wire logic        write_enable_n_i,
    input wire logic        array_mode_i,
    input wire logic [15:0] data_o,
    input wire logic        data_oe_n_o,
    input wire logic        hold_o,
    input wire logic        hold_oe_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cfg_q;
    logic [3:0]  cfg_age;
    logic        bclk_q;
    logic [3:0]  since_edge;
    // Decode of config writes, selected burst edge and hold level
    wire cfg_wr = psel_i && penable_i && pready_o && pwrite_i && paddr_i == 12'h000;
    wire sel_edge = cfg_q[6] ? (burst_clk_i && !bclk_q) : (!burst_clk_i && bclk_q);
    wire cfg_old = cfg_age > 4'h4;
    wire hold_on = hold_o == cfg_q[10];
    // Shadow of the configuration word, age since last write
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cfg_q <= 16'hbfcf;
            cfg_age <= 4'h0;
        end else begin
            cfg_q <= cfg_wr ? (pwdata_i[15:0] & 16'hbfcf) : cfg_q;
            cfg_age <= cfg_wr ? 4'h0 : (cfg_age == 4'hf ? cfg_age : cfg_age + 4'h1);
        end
    end
    // Cycles since the selected burst clock edge
    always_ff @(posedge clk_i) begin
        bclk_q <= burst_clk_i;
        if (srst_i || sel_edge) since_edge <= srst_i ? 4'hf : 4'h0;
        else since_edge <= (since_edge == 4'hf) ? since_edge : since_edge + 4'h1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    sequence s_take;
        psel_i && penable_i && !pready_o;
    endsequence
    sequence s_answer;
        pready_o ##1 !pready_o;
    endsequence
    AST_PREADY: assert property (s_take |=> s_answer)
        else $error("pready not a one cycle answer");
    AST_PSLVERR: assert property (pready_o |-> pslverr_o == !(paddr_i inside {12'h000, 12'h004}))
        else $error("pslverr wrong for address");
    AST_HOLD_TRI: assert property (chip_enable_n_i [*5] |-> hold_oe_n_o)
        else $error("hold driven while deselected");
    AST_HOLD_DRV: assert property (!chip_enable_n_i [*5] |-> !hold_oe_n_o)
        else $error("hold floating while selected");
    AST_ASYNC: assert property (cfg_old && cfg_q[15] && !hold_oe_n_o |-> hold_on)
        else $error("hold released in async mode");
    AST_WRITE: assert property ((!write_enable_n_i [*5]) ##0 (cfg_old && !hold_oe_n_o) |-> hold_on)
        else $error("hold released during write");
    AST_NONARRAY: assert property ((!array_mode_i [*3]) ##0 (cfg_old && !hold_oe_n_o) |-> hold_on)
        else $error("hold released outside array mode");
    AST_SYNC_ONLY: assert property (!hold_oe_n_o && !hold_on && cfg_old |-> !cfg_q[15])
        else $error("hold released without sync mode");
    AST_EDGE: assert property ($changed(data_o) && !hold_on && !hold_oe_n_o |-> since_edge inside {[4'h1:4'h7]})
        else $error("data changed off the selected edge");
    AST_DATA_OE: assert property ($stable({chip_enable_n_i, output_enable_n_i}) [*5]
        |-> data_oe_n_o == (chip_enable_n_i || output_enable_n_i))
        else $error("data drive enable wrong");
endmodule

// file: bench/fbrwc_host.sv
// Host model: burst clock, strobe, enables and word capture
module fbrwc_host (
    input  wire logic        clk_i,
    input  wire logic        hold_i,
    input  wire logic [15:0] data_i,
    output logic             bclk_o,
    output logic             adv_n_o,
    output logic             ce_n_o,
    output logic             oe_n_o,
    output logic             we_n_o,
    output logic [15:0]      addr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] words [$];
    int          hcnt;
    // Idle pins at time zero
    initial begin
        bclk_o = 1'b0;
        adv_n_o = 1'b1;
        ce_n_o = 1'b1;
        oe_n_o = 1'b1;
        we_n_o = 1'b1;
        addr_o = 16'h0000;
    end
    // One burst frame of an address edge plus n active edges, clock still outside it
    task automatic frame(input logic [15:0] a, input int n, input logic rise, input logic pol);
        words.delete();
        hcnt = 0;
        bclk_o <= !rise;
        ce_n_o <= 1'b0;
        oe_n_o <= 1'b0;
        adv_n_o <= 1'b0;
        addr_o <= a;
        repeat (8) @(posedge clk_i);
        for (int i = 0; i <= n; i++) begin
            // Sample a full burst clock period after launch, just before the next active edge; only ready words count
            if (i > 0 && hold_i === !pol) words.push_back(data_i);
            else if (i > 0 && hold_i === pol && words.size() > 0) hcnt++;
            bclk_o <= rise;
            repeat (8) @(posedge clk_i);
            adv_n_o <= 1'b1;
            addr_o <= ~a; // Released address no longer valid
            bclk_o <= !rise;
            repeat (8) @(posedge clk_i);
        end
        ce_n_o <= 1'b1;
        oe_n_o <= 1'b1;
    endtask
    // Write cycle with output enable high
    task automatic wcycle();
        @(posedge clk_i);
        ce_n_o <= 1'b0;
        we_n_o <= 1'b0;
        repeat (10) @(posedge clk_i);
        ce_n_o <= 1'b1;
        we_n_o <= 1'b1;
        @(posedge clk_i);
    endtask
endmodule

// file: bench/fbrwc_top_tb.sv
// Self-checking bench for the burst read hold-off control
module fbrwc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic        array_mode_i = 1'b1;
    logic [31:0] prdata_o, rd;
    logic        pready_o, pslverr_o, er, bclk, adv_n, ce_n, oe_n, we_n;
    logic [15:0] addr, data_o, array_addr_o, cf, a;
    logic        data_oe_n_o, hold_o, hold_oe_n_o;
    logic [15:0] q [$];
    wire  [15:0] array_data_i = ~array_addr_o;
    int          fails = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          h, k, n;
    logic [15:0] tcfg [12] = '{16'hbfcf, 16'h1cc7, 16'h1cc1, 16'h1cc2, 16'h1cc3,
                               16'h1cc9, 16'h24c7, 16'h1cca, 16'h1a87, 16'h1dc7,
                               16'h14c7, 16'h0cc7};
    logic [15:0] tst [12] = '{16'h0000, 16'h0000, 16'h0001, 16'h0005, 16'h000e,
                              16'h000c, 16'h000f, 16'h000d, 16'h0020, 16'h000e,
                              16'h0003, 16'h0000};
    int          tdly [12] = '{0, 0, 0, 0, 0, 0, 3, 1, 0, 1, 1, 0};
    fbrwc_top u_fbrwc_top (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .burst_clk_i(bclk),
        .address_valid_n_i(adv_n), .chip_enable_n_i(ce_n), .output_enable_n_i(oe_n),
        .write_enable_n_i(we_n), .addr_i(addr), .data_o(data_o), .data_oe_n_o(data_oe_n_o),
        .hold_o(hold_o), .hold_oe_n_o(hold_oe_n_o), .array_mode_i(array_mode_i),
        .array_data_i(array_data_i), .array_addr_o(array_addr_o));
    fbrwc_host u_fbrwc_host (.clk_i(clk_i), .hold_i(hold_o), .data_i(data_o), .bclk_o(bclk),
        .adv_n_o(adv_n), .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n), .addr_o(addr));
    // Clock and timeout
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            report_and_stop();
        end
    end
    function automatic logic [15:0] nxt(logic [15:0] x, logic [2:0] bl, logic bw);
        logic [15:0] m;
        m = (bl == 3'h1) ? 16'h0003 : (bl == 3'h2) ? 16'h0007 : 16'h000f;
        if (bw || bl == 3'h7) return x + 16'h0001;
        return (x & ~m) | ((x + 16'h0001) & m);
    endfunction
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd,
                       output logic [31:0] r, output logic e);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= ad;
        pwdata_i <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1) @(posedge clk_i);
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Register checks, then one burst frame per table row
    initial begin
        repeat (16) @(posedge clk_i);
        srst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        apb(1'b0, 12'h000, 32'h0, rd, er);
        check("config reset", 32'h0000bfcf, rd);
        apb(1'b1, 12'h000, 32'hffffffff, rd, er);
        apb(1'b0, 12'h000, 32'h0, rd, er);
        check("config reserved", 32'h0000bfcf, rd);
        apb(1'b1, 12'h004, 32'h00001234, rd, er);
        check("status write err", 32'h0, {31'h0, er});
        apb(1'b0, 12'h004, 32'h0, rd, er);
        check("status", 32'h0, rd);
        apb(1'b0, 12'h008, 32'h0, rd, er);
        check("unmapped err", 32'h1, {31'h0, er});
        for (int c = 0; c < 12; c++) begin
            cf = tcfg[c];
            n = cf[9] ? 23 : 24;
            h = cf[9] ? 2 : 1;
            apb(1'b1, 12'h000, {16'h0000, cf}, rd, er);
            array_mode_i <= (c != 1);
            u_fbrwc_host.frame(tst[c], n, cf[6], cf[10]);
            q = u_fbrwc_host.words;
            k = (cf[15] || c == 1) ? 0 : n - int'(cf[13:11]) - tdly[c];
            if (cf[8] && k > 0) check("early hold", tdly[c] + 1, u_fbrwc_host.hcnt);
            else begin
                check("words", k, q.size());
                check("row hold", tdly[c], u_fbrwc_host.hcnt);
                a = tst[c];
                for (int j = 0; j < q.size(); j++) begin
                    if (j > 0 && j % h == 0) a = nxt(a, cf[2:0], cf[3]);
                    check("word", {16'h0000, ~a}, {16'h0000, q[j]});
                end
            end
        end
        u_fbrwc_host.wcycle();
        report_and_stop();
    end
endmodule
bind fbrwc_top fbrwc_props u_fbrwc_props (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .burst_clk_i(burst_clk_i),
    .chip_enable_n_i(chip_enable_n_i), .write_enable_n_i(write_enable_n_i),
    .array_mode_i(array_mode_i), .data_o(data_o), .hold_o(hold_o), .hold_oe_n_o(hold_oe_n_o),
    .output_enable_n_i(output_enable_n_i), .data_oe_n_o(data_oe_n_o));
